// [verilog/flash_ctl_pkg.sv]
// Constants, command codes and sequence tables for the flash controller
package flash_ctl_pkg;
  // Clock and bus timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WE_PULSE_NS = 70;
  localparam int READ_ACC_NS = 85;
  localparam int ERASE_SUSP_US = 15;
  localparam int PROG_SUSP_US = 10;
  // Least times round up to whole cycles
  localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACC_CYC = (READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_SUSP_CYC =
    (ERASE_SUSP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_SUSP_CYC =
    (PROG_SUSP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Software register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_OK = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_VPP = 3;
  localparam int ST_SUSP = 4;
  localparam int ST_SUSP_ERASE = 5;
  localparam int ST_ID_MODE = 6;
  localparam int ST_CFI_MODE = 7;
  localparam int ST_REFUSED = 8;

  // Device status bit positions on the data bus
  localparam int POLL_STATUS_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;
  localparam int OP_FAILURE_BIT = 5;
  localparam int PROG_VOLTAGE_STATUS_BIT = 3;
  localparam int LOCK_DATA_BIT = 1;

  // Software command codes
  typedef enum logic [3:0] {
    CMD_READ = 4'h0, CMD_PROG = 4'h1, CMD_SECT_ERASE = 4'h2,
    CMD_CHIP_ERASE = 4'h3, CMD_SUSPEND = 4'h4, CMD_RESUME = 4'h5,
    CMD_ID_ENTRY = 4'h6, CMD_ID_EXIT = 4'h7, CMD_CFI_ENTRY = 4'h8,
    CMD_LOCK_PREG = 4'h9
  } cmd_t;

  // Flash bus cycle codes
  localparam logic [21:0] A_555 = 22'h000555;
  localparam logic [21:0] A_AAA = 22'h000aaa;
  localparam logic [21:0] A_CFI = 22'h000055;
  localparam logic [15:0] D_AA = 16'h00aa;
  localparam logic [15:0] D_55 = 16'h0055;
  localparam logic [15:0] D_80 = 16'h0080;
  localparam logic [15:0] D_PROG = 16'h00a0;
  localparam logic [15:0] D_CHIP = 16'h0010;
  localparam logic [15:0] D_SECT = 16'h0030;
  localparam logic [15:0] D_CFI = 16'h0098;
  localparam logic [15:0] D_SUSPEND = 16'h00b0;
  localparam logic [15:0] D_RESUME = 16'h00d0;
  localparam logic [15:0] D_ID_ENTRY = 16'h0090;
  localparam logic [15:0] D_ID_EXIT = 16'h00f0;
  localparam logic [15:0] D_LOCK_PREG = 16'h00c0;

  // Number of bus write cycles for a command
  function automatic logic [2:0] seq_len(input cmd_t c);
    case (c)
      CMD_PROG, CMD_LOCK_PREG: seq_len = 3'h4;
      CMD_SECT_ERASE, CMD_CHIP_ERASE: seq_len = 3'h6;
      CMD_ID_ENTRY: seq_len = 3'h3;
      default: seq_len = 3'h1;
    endcase
  endfunction : seq_len

  // Address and data of write cycle idx, packed {addr, data}
  function automatic logic [37:0] seq_word(input cmd_t c,
      input logic [2:0] idx, input logic [21:0] a, input logic [15:0] d);
    logic [15:0] third;
    logic [37:0] last;
    third = D_80;
    last = {A_555, D_ID_EXIT};
    case (c)
      CMD_PROG: begin
        third = D_PROG;
        last = {a, d};
      end
      CMD_LOCK_PREG: begin
        third = D_LOCK_PREG;
        last = {a, d & ~(16'h0001 << LOCK_DATA_BIT)};
      end
      CMD_SECT_ERASE: last = {a, D_SECT};
      CMD_CHIP_ERASE: last = {A_555, D_CHIP};
      // Third cycle is the last one, so it must carry the entry code
      CMD_ID_ENTRY: last = {A_555, D_ID_ENTRY};
      CMD_SUSPEND: last = {A_555, D_SUSPEND};
      CMD_RESUME: last = {a, D_RESUME};
      CMD_CFI_ENTRY: last = {A_CFI, D_CFI};
      default: last = {A_555, D_ID_EXIT};
    endcase
    if (idx == seq_len(c) - 3'h1) begin
      seq_word = last;
    end else begin
      case (idx)
        3'h0, 3'h3: seq_word = {A_555, D_AA};
        3'h1, 3'h4: seq_word = {A_AAA, D_55};
        default: seq_word = {A_555, third};
      endcase
    end
  endfunction : seq_word
endpackage : flash_ctl_pkg

// [verilog/flash_bus_cycle.sv]
// One asynchronous flash bus cycle, write or read, with strobe timing
`timescale 1ns/1ns
module flash_bus_cycle
  import flash_ctl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [21:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_dq,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic [21:0] o_addr,
  output logic [15:0] o_dq,
  output logic o_dq_oe,
  output logic o_ce_b,
  output logic o_oe_b,
  output logic o_we_b
);
  typedef enum logic [3:0] {
    B_IDLE = 4'b0001, B_SETUP = 4'b0010, B_STROBE = 4'b0100,
    B_HOLD = 4'b1000
  } bstate_t;

  bstate_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic write_q, next_write_q;
  logic next_done, next_dq_oe, next_ce_b, next_oe_b, next_we_b;
  logic [15:0] next_rdata, next_dq;
  logic [21:0] next_addr;

  // Strobe sequencing; write and output enables never overlap
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_write_q = write_q;
    next_done = 1'b0;
    next_rdata = o_rdata;
    next_addr = o_addr;
    next_dq = o_dq;
    next_dq_oe = o_dq_oe;
    next_ce_b = o_ce_b;
    next_oe_b = o_oe_b;
    next_we_b = o_we_b;
    case (state)
      B_IDLE: begin
        if (i_start) begin
          next_addr = i_addr;
          next_dq = i_wdata;
          next_dq_oe = i_write;
          next_write_q = i_write;
          next_ce_b = 1'b0;
          next_state = B_SETUP;
        end
      end
      B_SETUP: begin
        // Write enable only with output enable high
        if (write_q) begin
          next_we_b = 1'b0;
          next_cnt = 4'(WE_PULSE_CYC - 1);
        end else begin
          next_oe_b = 1'b0;
          next_cnt = 4'(READ_ACC_CYC - 1);
        end
        next_state = B_STROBE;
      end
      B_STROBE: begin
        if (cnt == 4'h0) begin
          next_we_b = 1'b1;
          next_oe_b = 1'b1;
          if (!write_q) begin
            next_rdata = i_dq;
          end
          next_state = B_HOLD;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      B_HOLD: begin
        // Data held one cycle past the rising write edge
        next_ce_b = 1'b1;
        next_dq_oe = 1'b0;
        next_done = 1'b1;
        next_state = B_IDLE;
      end
      default: next_state = B_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= B_IDLE;
      cnt <= 4'h0;
      write_q <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
      o_addr <= 22'h000000;
      o_dq <= 16'h0000;
      o_dq_oe <= 1'b0;
      o_ce_b <= 1'b1;
      o_oe_b <= 1'b1;
      o_we_b <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      write_q <= next_write_q;
      o_done <= next_done;
      o_rdata <= next_rdata;
      o_addr <= next_addr;
      o_dq <= next_dq;
      o_dq_oe <= next_dq_oe;
      o_ce_b <= next_ce_b;
      o_oe_b <= next_oe_b;
      o_we_b <= next_we_b;
    end
  end
endmodule : flash_bus_cycle

// [verilog/flash_status_eval.sv]
// Decodes two successive status reads into completion and error flags
`timescale 1ns/1ns
module flash_status_eval
  import flash_ctl_pkg::*;
(
  input wire logic [15:0] i_prev,
  input wire logic [15:0] i_cur,
  input wire logic i_cfg01,
  output logic o_finished,
  output logic o_fail,
  output logic o_vpp
);
  // Polling bit in mode 01, otherwise a stopped toggle bit
  assign o_finished = i_cfg01 ? i_cur[POLL_STATUS_BIT] :
    (i_prev[TOGGLE_STATUS_BIT] == i_cur[TOGGLE_STATUS_BIT]);
  assign o_fail = i_cur[OP_FAILURE_BIT];
  assign o_vpp = i_cur[PROG_VOLTAGE_STATUS_BIT];
endmodule : flash_status_eval

// [verilog/flash_host_ctl.sv]
// Host controller that issues flash commands and polls their status
`timescale 1ns/1ns
// Summary of operation
// - After failure, host writes id exit
// - Low program voltage: status, then id exit
// - No second erase while erase suspended
// - Resume is one cycle with plane address
// - Lock user half with data bit cleared
// - Id entry before reading, exit after
// - Reread poll bit after failure bit
module flash_host_ctl
  import flash_ctl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [15:0] i_flash_dq,
  output logic [21:0] o_flash_addr,
  output logic [15:0] o_flash_dq,
  output logic o_flash_dq_oe,
  output logic o_flash_ce_b,
  output logic o_flash_oe_b,
  output logic o_flash_we_b
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_WRITE = 6'b000010, S_READ = 6'b000100,
    S_POLL = 6'b001000, S_SWAIT = 6'b010000, S_EXIT = 6'b100000
  } state_t;

  state_t state, next_state;
  cmd_t cmd_q, next_cmd_q;
  logic [2:0] idx, next_idx;
  logic issued, next_issued;
  logic [21:0] op_addr, next_op_addr, susp_addr, next_susp_addr;
  logic [21:0] poll_addr, next_poll_addr;
  logic [15:0] wdata, next_wdata, last_rd, next_last_rd;
  logic [15:0] prev_rd, next_prev_rd;
  logic cfg01, next_cfg01;
  logic op_erase, next_op_erase, susp_erase, next_susp_erase;
  logic busy, next_busy, ok, next_ok, fail, next_fail;
  logic vpp, next_vpp, suspended, next_suspended;
  logic id_mode, next_id_mode, cfi_mode, next_cfi_mode;
  logic cfi_from_id, next_cfi_from_id, refused, next_refused;
  logic susp_pend, next_susp_pend, have_prev, next_have_prev;
  logic rechecked, next_rechecked;
  logic [8:0] wait_cnt, next_wait_cnt;
  logic [31:0] next_rdata;

  logic bus_start, bus_write, bus_done;
  logic [21:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  logic [37:0] word;
  logic st_finished, st_fail, st_vpp;
  logic cmd_wr, legal;
  cmd_t new_cmd;

  flash_bus_cycle u_bus (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_start(bus_start),
    .i_write(bus_write),
    .i_addr(bus_addr),
    .i_wdata(bus_wdata),
    .i_dq(i_flash_dq),
    .o_done(bus_done),
    .o_rdata(bus_rdata),
    .o_addr(o_flash_addr),
    .o_dq(o_flash_dq),
    .o_dq_oe(o_flash_dq_oe),
    .o_ce_b(o_flash_ce_b),
    .o_oe_b(o_flash_oe_b),
    .o_we_b(o_flash_we_b)
  );

  flash_status_eval u_eval (
    .i_prev(prev_rd),
    .i_cur(bus_rdata),
    .i_cfg01(cfg01),
    .o_finished(st_finished),
    .o_fail(st_fail),
    .o_vpp(st_vpp)
  );

  // Command acceptance: which orders the device may take now
  assign cmd_wr = i_wr && (i_addr == REG_CMD);
  assign new_cmd = cmd_t'(i_wdata[3:0]);
  always_comb begin
    legal = 1'b1;
    case (new_cmd)
      CMD_READ, CMD_ID_EXIT: legal = 1'b1;
      CMD_CFI_ENTRY: legal = !cfi_mode && !suspended;
      CMD_SECT_ERASE, CMD_CHIP_ERASE:
        legal = !suspended && !id_mode && !cfi_mode;
      CMD_PROG, CMD_LOCK_PREG:
        legal = (!suspended || susp_erase) && !id_mode && !cfi_mode;
      CMD_RESUME: legal = suspended && !id_mode && !cfi_mode;
      CMD_ID_ENTRY: legal = !id_mode && !cfi_mode && !suspended;
      default: legal = 1'b0;
    endcase
    // Suspend is only meaningful with an operation running
    if (new_cmd == CMD_SUSPEND) begin
      legal = 1'b0;
    end
  end

  assign word = seq_word(cmd_q, idx, op_addr, wdata);

  // Bus request drive: one cycle per step, reads during polling
  always_comb begin
    bus_start = 1'b0;
    bus_write = 1'b1;
    bus_addr = word[37:16];
    bus_wdata = word[15:0];
    if (!issued) begin
      case (state)
        S_WRITE, S_EXIT: bus_start = 1'b1;
        S_READ: begin
          bus_start = 1'b1;
          bus_write = 1'b0;
          bus_addr = op_addr;
        end
        S_POLL: begin
          bus_start = 1'b1;
          bus_write = 1'b0;
          bus_addr = poll_addr;
        end
        default: bus_start = 1'b0;
      endcase
    end
  end

  // Sequencer and register file next values
  always_comb begin
    next_state = state;
    next_cmd_q = cmd_q;
    next_idx = idx;
    next_issued = issued;
    next_op_addr = op_addr;
    next_susp_addr = susp_addr;
    next_poll_addr = poll_addr;
    next_wdata = wdata;
    next_last_rd = last_rd;
    next_prev_rd = prev_rd;
    next_cfg01 = cfg01;
    next_op_erase = op_erase;
    next_susp_erase = susp_erase;
    next_busy = busy;
    next_ok = ok;
    next_fail = fail;
    next_vpp = vpp;
    next_suspended = suspended;
    next_id_mode = id_mode;
    next_cfi_mode = cfi_mode;
    next_cfi_from_id = cfi_from_id;
    next_refused = refused;
    next_susp_pend = susp_pend;
    next_have_prev = have_prev;
    next_rechecked = rechecked;
    next_wait_cnt = wait_cnt;
    if (bus_start) begin
      next_issued = 1'b1;
    end
    if (i_wr && i_addr == REG_ADDR) begin
      next_op_addr = i_wdata[21:0];
    end
    if (i_wr && i_addr == REG_WDATA) begin
      next_wdata = i_wdata[15:0];
    end
    if (i_wr && i_addr == REG_CFG) begin
      next_cfg01 = i_wdata[0];
    end
    case (state)
      S_IDLE: begin
        if (cmd_wr) begin
          next_refused = !legal;
          if (legal) begin
            next_cmd_q = new_cmd;
            next_idx = 3'h0;
            next_busy = 1'b1;
            next_ok = 1'b0;
            next_fail = 1'b0;
            next_vpp = 1'b0;
            next_state = (new_cmd == CMD_READ) ? S_READ : S_WRITE;
          end
        end
      end
      S_READ: begin
        if (bus_done) begin
          next_issued = 1'b0;
          next_last_rd = bus_rdata;
          next_ok = 1'b1;
          next_busy = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_WRITE: begin
        if (bus_done) begin
          next_issued = 1'b0;
          next_idx = idx + 3'h1;
          if (idx == seq_len(cmd_q) - 3'h1) begin
            next_state = S_IDLE;
            next_busy = 1'b0;
            next_ok = 1'b1;
            next_have_prev = 1'b0;
            next_rechecked = 1'b0;
            case (cmd_q)
              CMD_PROG, CMD_LOCK_PREG, CMD_SECT_ERASE, CMD_CHIP_ERASE: begin
                next_busy = 1'b1;
                next_ok = 1'b0;
                next_poll_addr = op_addr;
                next_op_erase = (cmd_q == CMD_SECT_ERASE) ||
                  (cmd_q == CMD_CHIP_ERASE);
                next_state = S_POLL;
              end
              CMD_SUSPEND: begin
                // Wait the suspend latency of the running operation, erase or program
                next_busy = 1'b1;
                next_ok = 1'b0;
                next_wait_cnt = op_erase ? 9'(ERASE_SUSP_CYC - 1) :
                  9'(PROG_SUSP_CYC - 1);
                next_state = S_SWAIT;
              end
              CMD_RESUME: begin
                // Plane address came from the address register
                next_busy = 1'b1;
                next_ok = 1'b0;
                next_suspended = 1'b0;
                next_poll_addr = susp_addr;
                next_op_erase = susp_erase;
                next_state = S_POLL;
              end
              CMD_ID_ENTRY: next_id_mode = 1'b1;
              CMD_CFI_ENTRY: begin
                next_cfi_mode = 1'b1;
                next_cfi_from_id = id_mode;
              end
              default: begin
                // Exit steps query mode back one level
                if (cfi_mode) begin
                  next_cfi_mode = 1'b0;
                  next_id_mode = cfi_from_id;
                end else begin
                  next_id_mode = 1'b0;
                end
              end
            endcase
          end
        end
      end
      S_POLL: begin
        // Only suspend is taken while the operation runs
        if (cmd_wr) begin
          next_refused = (new_cmd != CMD_SUSPEND) || suspended;
          if (new_cmd == CMD_SUSPEND && !suspended) begin
            next_susp_pend = 1'b1;
          end
        end
        if (bus_done) begin
          next_issued = 1'b0;
          next_prev_rd = bus_rdata;
          next_last_rd = bus_rdata;
          next_have_prev = 1'b1;
          if (susp_pend) begin
            next_susp_pend = 1'b0;
            next_susp_addr = poll_addr;
            next_susp_erase = op_erase;
            next_suspended = 1'b1;
            next_cmd_q = CMD_SUSPEND;
            next_idx = 3'h0;
            next_state = S_WRITE;
          end else if (have_prev || cfg01) begin
            if (st_finished && !st_fail && !st_vpp) begin
              // Mode 00 is back in array read; 01 needs exit
              next_ok = 1'b1;
              next_state = cfg01 ? S_EXIT : S_IDLE;
              next_busy = cfg01;
            end else if ((st_fail || st_vpp) && (rechecked || st_finished)) begin
              // Device holds status mode until exit
              next_fail = st_fail;
              next_vpp = st_vpp;
              next_state = S_EXIT;
            end else if (st_fail || st_vpp) begin
              next_rechecked = 1'b1;
            end
          end
        end
      end
      S_EXIT: begin
        if (bus_done) begin
          next_issued = 1'b0;
          next_busy = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_SWAIT: begin
        if (wait_cnt == 9'h000) begin
          next_busy = 1'b0;
          next_ok = 1'b1;
          next_state = S_IDLE;
        end else begin
          next_wait_cnt = wait_cnt - 9'h001;
        end
      end
      default: next_state = S_IDLE;
    endcase
    // Exit cycle reuses the write path with a fixed code
    if (next_state == S_EXIT && state != S_EXIT) begin
      next_cmd_q = CMD_ID_EXIT;
      next_idx = 3'h0;
    end
  end

  // Register read port; data stands only in the cycle after the strobe
  always_comb begin
    next_rdata = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        REG_CMD: next_rdata = {28'h0000000, cmd_q};
        REG_ADDR: next_rdata = {10'h000, op_addr};
        REG_WDATA: next_rdata = {16'h0000, wdata};
        REG_CFG: next_rdata = {31'h00000000, cfg01};
        REG_STATUS: next_rdata = {23'h000000, refused, cfi_mode, id_mode,
          susp_erase, suspended, vpp, fail, ok, busy};
        REG_RDATA: next_rdata = {16'h0000, last_rd};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= S_IDLE;
      cmd_q <= CMD_READ;
      idx <= 3'h0;
      issued <= 1'b0;
      op_addr <= 22'h000000;
      susp_addr <= 22'h000000;
      poll_addr <= 22'h000000;
      wdata <= 16'h0000;
      last_rd <= 16'h0000;
      prev_rd <= 16'h0000;
      cfg01 <= 1'b0;
      op_erase <= 1'b0;
      susp_erase <= 1'b0;
      busy <= 1'b0;
      ok <= 1'b0;
      fail <= 1'b0;
      vpp <= 1'b0;
      suspended <= 1'b0;
      id_mode <= 1'b0;
      cfi_mode <= 1'b0;
      cfi_from_id <= 1'b0;
      refused <= 1'b0;
      susp_pend <= 1'b0;
      have_prev <= 1'b0;
      rechecked <= 1'b0;
      wait_cnt <= 9'h000;
      o_rdata <= 32'h00000000;
    end else begin
      state <= next_state;
      cmd_q <= next_cmd_q;
      idx <= next_idx;
      issued <= next_issued;
      op_addr <= next_op_addr;
      susp_addr <= next_susp_addr;
      poll_addr <= next_poll_addr;
      wdata <= next_wdata;
      last_rd <= next_last_rd;
      prev_rd <= next_prev_rd;
      cfg01 <= next_cfg01;
      op_erase <= next_op_erase;
      susp_erase <= next_susp_erase;
      busy <= next_busy;
      ok <= next_ok;
      fail <= next_fail;
      vpp <= next_vpp;
      suspended <= next_suspended;
      id_mode <= next_id_mode;
      cfi_mode <= next_cfi_mode;
      cfi_from_id <= next_cfi_from_id;
      refused <= next_refused;
      susp_pend <= next_susp_pend;
      have_prev <= next_have_prev;
      rechecked <= next_rechecked;
      wait_cnt <= next_wait_cnt;
      o_rdata <= next_rdata;
    end
  end
endmodule : flash_host_ctl

// [bench/flash_dev_model.sv]
// Behavioural flash part with status bits and a small array
`timescale 1ns/1ns
module flash_dev_model
  import flash_ctl_pkg::*;
(
  input wire logic i_ce_b,
  input wire logic i_oe_b,
  input wire logic i_we_b,
  input wire logic [21:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_cfg01,
  input wire logic i_fail,
  input wire logic i_vpp_low,
  output logic [15:0] o_dq
);
  logic [15:0] mem [1024] = '{default: 16'hffff};
  logic [15:0] prev = 16'h0, q = 16'h0, ld = 16'h0;
  logic [21:0] pa = 22'h0;
  logic tg = 1'b0, pg = 1'b0, st = 1'b0, b5 = 1'b0, b3 = 1'b0;
  logic idm = 1'b0, lk = 1'b1;
  int busy = 0, sus = 0;
  // Released bus shows the inverse, so a stale word never passes
  assign o_dq = (!i_oe_b && !i_ce_b) ? q : ~q;
  // Decode; nothing starts while output enable is low
  always @(posedge i_we_b) if (!i_ce_b && i_oe_b) begin
    if (i_dq == D_SUSPEND && busy > 0) begin
      {sus, busy, st} = {busy, 32'd0, 1'b0};
    end else if (i_dq == D_RESUME && sus > 0 && i_addr == pa) begin
      {busy, sus} = {sus, 32'd0};
    end else if (i_dq == D_ID_EXIT) begin
      {st, idm} = 2'b00;
    end else if (prev == D_LOCK_PREG) begin
      // Locking the user half runs like a short program
      {lk, ld, busy, pg} = {i_dq[LOCK_DATA_BIT], i_dq, 32'd4, 1'b1};
    end else if (prev == D_55 && i_dq == D_ID_ENTRY) begin
      idm = 1'b1;
    end else if (busy == 0 && !st && prev == D_PROG) begin
      mem[i_addr[9:0]] = mem[i_addr[9:0]] & i_dq;
      {ld, busy, pg, pa} = {i_dq, 32'd4, 1'b1, i_addr};
    end else if (busy == 0 && !st && sus == 0 && prev == D_55 &&
        (i_dq == D_SECT || i_dq == D_CHIP)) begin
      {busy, pg, pa} = {32'd20, 1'b0, i_addr};
    end
    prev = i_dq;
  end
  // Busy reads flip bit 6; the last one decides status mode
  always @(negedge i_oe_b) if (!i_ce_b) begin
    if (busy > 0) begin
      busy--;
      tg = ~tg;
      q = {8'h0, !i_cfg01 & pg & ~ld[7], tg, 6'h0};
      if (busy == 0) {b5, b3} = {i_fail, i_vpp_low};
      if (busy == 0) st = i_cfg01 | i_fail | i_vpp_low;
    end else if (st) q = {8'h0, 1'b1, tg, b5, 1'b0, b3, 3'h0};
    else if (idm) q = {14'h0, lk, 1'b0};
    else q = mem[i_addr[9:0]];
  end
endmodule : flash_dev_model

// [bench/flash_host_ctl_monitor.sv]
// Checker on flash strobes and the register read port
`timescale 1ns/1ns
module flash_host_ctl_monitor (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [21:0] o_flash_addr,
  input wire logic o_flash_dq_oe,
  input wire logic o_flash_ce_b,
  input wire logic o_flash_oe_b,
  input wire logic o_flash_we_b
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_we_oe_apart: assert property (o_flash_we_b || o_flash_oe_b)
    else $error("write and output strobes overlap");
  a_we_in_ce: assert property (!o_flash_we_b |-> !o_flash_ce_b)
    else $error("write strobe outside chip enable");
  a_we_drives: assert property (!o_flash_we_b |-> o_flash_dq_oe)
    else $error("write without data drive");
  a_read_float: assert property (!o_flash_oe_b |-> !o_flash_dq_oe)
    else $error("data driven during read");
  a_we_width: assert property ($fell(o_flash_we_b) |=>
      !o_flash_we_b ##1 o_flash_we_b) else $error("write pulse length");
  a_oe_width: assert property ($fell(o_flash_oe_b) |=>
      !o_flash_oe_b ##1 !o_flash_oe_b ##1 o_flash_oe_b)
    else $error("read pulse length");
  a_addr_hold: assert property (!o_flash_ce_b && !$past(o_flash_ce_b)
      |-> $stable(o_flash_addr)) else $error("address moved in cycle");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : flash_host_ctl_monitor

bind flash_host_ctl flash_host_ctl_monitor i_mon (.i_clk, .i_rst_b, .i_rd,
  .o_rdata, .o_flash_addr, .o_flash_dq_oe, .o_flash_ce_b, .o_flash_oe_b,
  .o_flash_we_b);

// [bench/flash_status_suspend_control_tb_top.sv]
// Bench for the flash host controller and a behavioural flash part
`timescale 1ns/1ns
module flash_status_suspend_control_tb_top
  import flash_ctl_pkg::*;
;
  // Rows: command, {cfg01, fail, low vpp}, expected status [3:0]
  logic [10:0] rows [5] = '{11'h082, 11'h0c2, 11'h164, 11'h098, 11'h182};
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, s;
  logic [21:0] fa;
  logic [15:0] fq, mq;
  logic foe, ce_b, oe_b, we_b;
  logic [2:0] mode = 3'h0;
  int failures = 0, checks_done = 0, cyc = 0;
  wire logic [15:0] dq = foe ? fq : mq;
  flash_host_ctl i_dut (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_flash_dq(dq), .o_flash_addr(fa), .o_flash_dq(fq),
    .o_flash_dq_oe(foe), .o_flash_ce_b(ce_b), .o_flash_oe_b(oe_b),
    .o_flash_we_b(we_b));
  flash_dev_model i_dev (.i_ce_b(ce_b), .i_oe_b(oe_b), .i_we_b(we_b),
    .i_addr(fa), .i_dq(fq), .i_cfg01(mode[2]), .i_fail(mode[1]),
    .i_vpp_low(mode[0]), .o_dq(mq));
  always #20 i_clk = ~i_clk;
  // Ceiling well above the longest run, cuts a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] v, e);
    checks_done++;
    if (v !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, v);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  // Read data stand only in the next cycle, so take them mid-cycle
  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    s = o_rdata;
    @(posedge i_clk);
  endtask : rd
  task automatic run(input logic [3:0] c, input logic [21:0] a,
      input logic [15:0] d, input int n);
    wr(REG_ADDR, {10'h0, a});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CMD, {28'h0, c});
    repeat (n) begin
      rd(REG_STATUS);
      if (s[ST_BUSY] === 1'b0) break;
    end
  endtask : run
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    rd(REG_STATUS);
    chk("status reset", s, 32'h0);
    rd(8'h1c);
    chk("unmapped", s, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      mode <= rows[i][6:4];
      wr(REG_CFG, {31'h0, rows[i][6]});
      run(rows[i][10:7], 22'h100, 16'h1204, 600);
      chk("outcome", {28'h0, s[3:0]}, {28'h0, rows[i][3:0]});
      $display("test row %0d done", i);
    end
    mode <= 3'h0;
    wr(REG_CFG, 32'h0);
    run(CMD_PROG, 22'h40, 16'h00c7, 600);
    run(CMD_PROG, 22'h40, 16'hff85, 600);
    run(CMD_READ, 22'h40, 16'h0, 600);
    rd(REG_RDATA);
    chk("zeros kept", s, 32'h85);
    mode <= 3'h4;
    wr(REG_CFG, 32'h1);
    run(CMD_SECT_ERASE, 22'h200, 16'h0, 0);
    repeat (80) @(posedge i_clk);
    run(CMD_SUSPEND, 22'h200, 16'h0, 600);
    chk("suspended", {30'h0, s[5:4]}, 32'h3);
    run(CMD_SECT_ERASE, 22'h300, 16'h0, 600);
    chk("second erase", {31'h0, s[ST_REFUSED]}, 32'h1);
    run(CMD_RESUME, 22'h200, 16'h0, 600);
    chk("resumed", {27'h0, s[4:0]}, 32'h2);
    // Suspend lands while the program is still being polled
    run(CMD_PROG, 22'h44, 16'h0f0f, 0);
    repeat (26) @(posedge i_clk);
    run(CMD_SUSPEND, 22'h44, 16'h0, 600);
    chk("prog suspended", {30'h0, s[5:4]}, 32'h1);
    run(CMD_RESUME, 22'h44, 16'h0, 600);
    chk("prog resumed", {27'h0, s[4:0]}, 32'h2);
    $display("test suspend done");
    run(CMD_ID_ENTRY, 22'h0, 16'h0, 600);
    run(CMD_CFI_ENTRY, 22'h0, 16'h0, 600);
    chk("query in", {30'h0, s[7:6]}, 32'h3);
    run(CMD_ID_EXIT, 22'h0, 16'h0, 600);
    chk("query exit", {30'h0, s[7:6]}, 32'h1);
    run(CMD_ID_EXIT, 22'h0, 16'h0, 600);
    chk("id exit", {30'h0, s[7:6]}, 32'h0);
    $display("test modes done");
    // Lock data bit is forced low even when software leaves it set
    run(CMD_LOCK_PREG, 22'h80, 16'hffff, 600);
    run(CMD_ID_ENTRY, 22'h0, 16'h0, 600);
    run(CMD_READ, 22'h82, 16'h0, 600);
    rd(REG_RDATA);
    chk("locked", {31'h0, s[1]}, 32'h0);
    run(CMD_ID_EXIT, 22'h0, 16'h0, 600);
    $display("test lock done");
    test_done();
  end
endmodule : flash_status_suspend_control_tb_top
